// ==== ir_remote_pkg.sv ====
// Constants shared by the infrared remote compare-buffer block.
// Operation
// - Buffer disabled: compare counter with written lengths
// - Buffer enabled: compare counter with shadow buffers
// - Busy set on write while buffer enabled, cleared on transfer
// - Data length busy, bit 9, blocks writes
// - Carrier length busy, bit 8, blocks writes
// - Reset initialises run, count, flags
package ir_remote_pkg;
    localparam int          LEN_WIDTH       = 16;
    localparam logic [15:0] LEN_RESET       = 16'h0000;
    localparam logic [15:0] COUNT_RESET     = 16'h0000;
    localparam int          BUSY_AP_BIT     = 8;
    localparam int          BUSY_DB_BIT     = 9;
    localparam int          STATUS_WIDTH    = 16;
    typedef enum logic [1:0] {
        st_idle,
        st_run,
        st_done
    } run_state_t;
endpackage : ir_remote_pkg

// ==== length_buffer.sv ====
// One compare-length register with its shadow buffer and busy flag.
`timescale 1ns/10ps
`default_nettype none
module length_buffer
    import ir_remote_pkg::*;
#(
    parameter int WIDTH = LEN_WIDTH
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             buffer_enable,
    input  wire logic             wr_en,
    input  wire logic [WIDTH-1:0] wr_data,
    input  wire logic             match,
    output logic      [WIDTH-1:0] written_value,
    output logic      [WIDTH-1:0] compare_value,
    output logic                  busy
);
    logic [WIDTH-1:0] value_reg;
    logic [WIDTH-1:0] shadow_reg;
    logic             busy_reg;
    logic             accept;

    assign accept = wr_en && !(buffer_enable && busy_reg);

    always_ff @(posedge clk) begin
        if (rst) begin
            value_reg <= LEN_RESET;
        end else if (accept) begin
            value_reg <= wr_data;
        end
    end

    // Shadow loads at a buffered match; a write in the same cycle is refused, since busy still blocks it.
    always_ff @(posedge clk) begin
        if (rst) begin
            shadow_reg <= LEN_RESET;
            busy_reg   <= 1'b0;
        end else if (!buffer_enable) begin
            shadow_reg <= value_reg;
            busy_reg   <= 1'b0;
        end else if (accept) begin
            busy_reg   <= 1'b1;
        end else if (busy_reg && match) begin
            shadow_reg <= value_reg;
            busy_reg   <= 1'b0;
        end
    end

    assign written_value = value_reg;
    assign compare_value = buffer_enable ? shadow_reg : value_reg;
    assign busy          = busy_reg;
endmodule : length_buffer
`default_nettype wire

// ==== ir_remote_unit.sv ====
// Counter, compare and output stage of the infrared remote transmitter.
`timescale 1ns/10ps
`default_nettype none
module ir_remote_unit
    import ir_remote_pkg::*;
#(
    parameter int WIDTH = LEN_WIDTH
) (
    input  wire logic                    clk,
    input  wire logic                    rst,
    input  wire logic                    counter_run,
    input  wire logic                    preset,
    input  wire logic                    one_shot,
    input  wire logic                    counter_reset_bit,
    input  wire logic                    compare_buffer_enable,
    input  wire logic                    carrier_modulation_enable,
    input  wire logic                    output_invert,
    input  wire logic                    carrier_in,
    input  wire logic                    data_bit_in,
    input  wire logic                    carrier_pattern_length_we,
    input  wire logic [WIDTH-1:0]        carrier_pattern_length,
    input  wire logic                    data_bit_length_we,
    input  wire logic [WIDTH-1:0]        data_bit_length,
    input  wire logic                    irq_clear_ap,
    input  wire logic                    irq_clear_db,
    output logic      [WIDTH-1:0]        carrier_pattern_length_reg,
    output logic      [WIDTH-1:0]        data_bit_length_reg,
    output logic      [WIDTH-1:0]        data_bit_count,
    output logic      [STATUS_WIDTH-1:0] status_flag_reg,
    output logic                         ir_out
);
    logic [WIDTH-1:0] count_reg;
    logic [WIDTH-1:0] ap_written;
    logic [WIDTH-1:0] db_written;
    logic [WIDTH-1:0] ap_cmp;
    logic [WIDTH-1:0] db_cmp;
    logic             ap_busy;
    logic             db_busy;
    logic             match_ap;
    logic             match_db;
    logic             running_reg;
    logic             db_flag_reg;
    logic             ap_flag_reg;
    logic             out_reg;
    logic [WIDTH-1:0] ap_len_reg;
    logic [WIDTH-1:0] db_len_reg;
    logic [WIDTH-1:0] count_out_reg;
    logic [STATUS_WIDTH-1:0] status_next;
    logic [STATUS_WIDTH-1:0] status_reg;
    run_state_t       state_reg;

    // ********************************************************************
    // Compare buffers
    // ********************************************************************
    length_buffer #(.WIDTH(WIDTH)) ap_buffer (
        .clk           (clk),
        .rst           (rst),
        .buffer_enable (compare_buffer_enable),
        .wr_en         (carrier_pattern_length_we),
        .wr_data       (carrier_pattern_length),
        .match         (match_ap),
        .written_value (ap_written),
        .compare_value (ap_cmp),
        .busy          (ap_busy)
    );

    length_buffer #(.WIDTH(WIDTH)) db_buffer (
        .clk           (clk),
        .rst           (rst),
        .buffer_enable (compare_buffer_enable),
        .wr_en         (data_bit_length_we),
        .wr_data       (data_bit_length),
        .match         (match_db),
        .written_value (db_written),
        .compare_value (db_cmp),
        .busy          (db_busy)
    );

    assign match_ap = (state_reg == st_run) && (count_reg == ap_cmp);
    assign match_db = (state_reg == st_run) && (count_reg == db_cmp);

    // ********************************************************************
    // Counter and run control
    // ********************************************************************
    // The counter restarts at each data-bit match; one-shot stops after one bit.
    always_ff @(posedge clk) begin
        if (rst || counter_reset_bit) begin
            state_reg <= st_idle;
            count_reg <= COUNT_RESET;
        end else begin
            case (state_reg)
                st_idle: begin
                    if (counter_run) begin
                        state_reg <= st_run;
                        count_reg <= preset ? db_cmp : COUNT_RESET;
                    end
                end
                st_run: begin
                    if (!counter_run) begin
                        state_reg <= st_idle;
                    end else if (match_db) begin
                        count_reg <= COUNT_RESET;
                        if (one_shot) begin
                            state_reg <= st_done;
                        end
                    end else begin
                        count_reg <= count_reg + 1'b1;
                    end
                end
                st_done: begin
                    state_reg <= st_done;
                end
                default: begin
                    state_reg <= st_idle;
                end
            endcase
        end
    end

    // ********************************************************************
    // Flags
    // ********************************************************************
    always_ff @(posedge clk) begin
        if (rst) begin
            running_reg <= 1'b0;
            db_flag_reg <= 1'b0;
            ap_flag_reg <= 1'b0;
        end else begin
            running_reg <= (state_reg == st_run);
            db_flag_reg <= match_db || (db_flag_reg && !irq_clear_db);
            ap_flag_reg <= match_ap || (ap_flag_reg && !irq_clear_ap);
        end
    end

    always_comb begin
        status_next              = '0;
        status_next[BUSY_AP_BIT] = ap_busy;
        status_next[BUSY_DB_BIT] = db_busy;
        status_next[2]           = running_reg;
        status_next[1]           = ap_flag_reg;
        status_next[0]           = db_flag_reg;
    end

    // ********************************************************************
    // Output stage
    // ********************************************************************
    // Output inversion is expected off when modulation is off.
    always_ff @(posedge clk) begin
        if (rst) begin
            out_reg       <= 1'b0;
            ap_len_reg    <= LEN_RESET;
            db_len_reg    <= LEN_RESET;
            count_out_reg <= COUNT_RESET;
            status_reg    <= '0;
        end else begin
            out_reg       <= (data_bit_in && (carrier_in || !carrier_modulation_enable))
                             ^ output_invert;
            ap_len_reg    <= ap_written;
            db_len_reg    <= db_written;
            count_out_reg <= count_reg;
            status_reg    <= status_next;
        end
    end

    assign ir_out                     = out_reg;
    assign carrier_pattern_length_reg = ap_len_reg;
    assign data_bit_length_reg        = db_len_reg;
    assign data_bit_count             = count_out_reg;
    assign status_flag_reg            = status_reg;
endmodule : ir_remote_unit
`default_nettype wire

// ==== ir_remote_properties.sv ====
// Port checker for the infrared remote compare-buffer block.
`timescale 1ns/10ps
`default_nettype none
module ir_remote_properties
    import ir_remote_pkg::*;
#(
    parameter int WIDTH = LEN_WIDTH
) (
    input wire logic                    clk,
    input wire logic                    rst,
    input wire logic                    compare_buffer_enable,
    input wire logic                    carrier_pattern_length_we,
    input wire logic [WIDTH-1:0]        carrier_pattern_length,
    input wire logic                    data_bit_length_we,
    input wire logic [WIDTH-1:0]        carrier_pattern_length_reg,
    input wire logic [WIDTH-1:0]        data_bit_length_reg,
    input wire logic [WIDTH-1:0]        data_bit_count,
    input wire logic [STATUS_WIDTH-1:0] status_flag_reg
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    chk_ap_write_direct: assert property (
        !compare_buffer_enable && carrier_pattern_length_we |-> ##2
        carrier_pattern_length_reg == $past(carrier_pattern_length, 2)) else $error("ap write lost");
    chk_db_busy_set: assert property (
        (compare_buffer_enable && data_bit_length_we ##1 !status_flag_reg[9]) |=>
        status_flag_reg[9]) else $error("db busy not set");
    chk_db_write_block: assert property (
        status_flag_reg[9] && $past(compare_buffer_enable) |=> $stable(data_bit_length_reg))
        else $error("db write taken while busy");
    chk_ap_write_block: assert property (
        status_flag_reg[8] && $past(compare_buffer_enable) |=> $stable(carrier_pattern_length_reg))
        else $error("ap write taken while busy");
    chk_reset_clears: assert property (
        $past(rst) |-> data_bit_count == 16'h0000 && status_flag_reg == 16'h0000)
        else $error("outputs not cleared by reset");
    chk_db_clear_match: assert property (
        $fell(status_flag_reg[9]) |-> data_bit_count == 16'h0000) else $error("db busy off-match");
    chk_no_busy_direct: assert property (
        !compare_buffer_enable ##1 !compare_buffer_enable |=> status_flag_reg[9:8] == 2'b00)
        else $error("busy while unbuffered");
endmodule : ir_remote_properties
bind ir_remote_unit ir_remote_properties #(.WIDTH(WIDTH)) u_chk (.*);
`default_nettype wire

// ==== ir_led_model.sv ====
// Infrared LED module model that counts light pulses on its drive line.
`timescale 1ns/10ps
`default_nettype none
module ir_led_model (
    input  wire logic clk,
    input  wire logic led_drive,
    output var  int   pulses
);
    logic last_reg = 1'b0;
    initial pulses = 0;
    // A plain process, since both variables also take a start value above.
    always @(posedge clk) begin
        last_reg <= led_drive;
        pulses   <= pulses + int'(led_drive && !last_reg);
    end
endmodule : ir_led_model
`default_nettype wire

// ==== ir_remote_unit_tb.sv ====
// Self-checking testbench for the infrared remote compare-buffer block.
`timescale 1ns/10ps
`default_nettype none
module ir_remote_unit_tb;
    import ir_remote_pkg::*;
    logic clk, rst, counter_run, preset, one_shot, counter_reset_bit, compare_buffer_enable;
    logic carrier_modulation_enable, output_invert, carrier_in, data_bit_in, ir_out;
    logic carrier_pattern_length_we, data_bit_length_we, irq_clear_ap, irq_clear_db;
    logic [15:0] carrier_pattern_length, data_bit_length, carrier_pattern_length_reg;
    logic [15:0] data_bit_length_reg, data_bit_count, status_flag_reg, top;
    int fail_count, num_checks, pulses;
    ir_remote_unit DUT (.*);
    ir_led_model led (.clk(clk), .led_drive(ir_out), .pulses(pulses));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    task step(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask : step
    task check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task finish_test;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : finish_test
    task wr(input logic ap, input logic [15:0] v);
        step(1);
        carrier_pattern_length_we = ap;
        data_bit_length_we = !ap;
        carrier_pattern_length = v;
        data_bit_length = v;
        step(1);
        carrier_pattern_length_we = 1'b0;
        data_bit_length_we = 1'b0;
    endtask : wr
    task peak(input logic [15:0] exp);
        top = 16'h0000;
        repeat (24) begin
            step(1);
            if (data_bit_count > top) top = data_bit_count;
        end
        check("count peak", top, exp);
    endtask : peak
    initial begin
        {rst, counter_run, preset, one_shot, counter_reset_bit, compare_buffer_enable} = 6'h00;
        {carrier_modulation_enable, output_invert, carrier_in, data_bit_in} = 4'h2;
        {carrier_pattern_length_we, data_bit_length_we, irq_clear_ap, irq_clear_db} = 4'h0;
        {carrier_pattern_length, data_bit_length, fail_count, num_checks} = '0;
        rst = 1'b1;
        step(8);
        rst = 1'b0;
        check("count", data_bit_count, COUNT_RESET);
        wr(1'b0, 16'h0005);
        wr(1'b1, 16'h0002);
        step(1);
        check("db length", data_bit_length_reg, 16'h0005);
        counter_run = 1'b1;
        peak(16'h0005);
        compare_buffer_enable = 1'b1;
        wr(1'b0, 16'h0003);
        wr(1'b0, 16'h0007);
        check("db busy", 16'(status_flag_reg[9]), 16'h0001);
        check("db refused", data_bit_length_reg, 16'h0003);
        wr(1'b1, 16'h0004);
        wr(1'b1, 16'h0009);
        check("ap busy", 16'(status_flag_reg[8]), 16'h0001);
        check("ap refused", carrier_pattern_length_reg, 16'h0004);
        for (int i = 0; i < 60 && status_flag_reg[9:8] != 2'b00; i++) step(1);
        check("busy cleared", 16'(status_flag_reg[9:8]), 16'h0000);
        peak(16'h0003);
        data_bit_in = 1'b1;
        step(3);
        check("ir out", 16'(ir_out), 16'h0001);
        check("led pulses", 16'(pulses), 16'h0001);
        data_bit_in = 1'b0;
        one_shot = 1'b1;
        {irq_clear_ap, irq_clear_db} = 2'b11;
        step(12);
        {irq_clear_ap, irq_clear_db} = 2'b00;
        counter_reset_bit = 1'b1;
        step(1);
        {counter_reset_bit, one_shot} = 2'b00;
        step(5);
        rst = 1'b1;
        step(2);
        rst = 1'b0;
        check("status", status_flag_reg, 16'h0000);
        check("count", data_bit_count, COUNT_RESET);
        finish_test();
    end
endmodule : ir_remote_unit_tb
`default_nettype wire
